// File: bit_test_skip_unit_bench.sv
// Self-checking bench for the bit-test-and-skip unit
`default_nettype none
module bit_test_skip_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 mclk_i = 1'b0;
  logic                 reset_i = 1'b1;
  logic                 instr_valid_i = 1'b0;
  logic [15:0]          instr_i = 16'h0000;
  logic                 ext_set_i = 1'b0;
  logic [3:0]           bank_select_register_i = 4'h7;
  logic [11:0]          index_base_i = 12'h3A0;
  logic [7:0]           rd_data_i = 8'h00;
  logic [11:0]          rd_addr_o;
  logic                 rd_en_o, is_bit_test_o, discard_fetch_o;
  logic                 no_operation_cycle_o, skip_taken_o;
  btsu_pkg::btsu_mode_t addr_mode_o;
  int                   miscompares = 0;
  int                   cmp_count = 0;
  int                   cycles = 0;
  btsu_core u_dut (.mclk_i(mclk_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .ext_set_i(ext_set_i),
    .bank_select_register_i(bank_select_register_i),
    .index_base_i(index_base_i), .rd_data_i(rd_data_i),
    .rd_addr_o(rd_addr_o), .rd_en_o(rd_en_o), .is_bit_test_o(is_bit_test_o),
    .discard_fetch_o(discard_fetch_o),
    .no_operation_cycle_o(no_operation_cycle_o),
    .skip_taken_o(skip_taken_o), .addr_mode_o(addr_mode_o));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Skip decision, then the flush cycle that follows a skip
  task automatic run_test(input logic [3:0] op, input logic [2:0] b,
                          input logic [7:0] data, input logic skip);
    @(negedge mclk_i);
    instr_valid_i = 1'b1;
    instr_i = {op, b, 1'b1, 8'h21};
    rd_data_i = data;
    #1;
    check({is_bit_test_o, rd_en_o}, 2'h3);
    check(discard_fetch_o, skip);
    @(negedge mclk_i);
    check(no_operation_cycle_o, skip);
    check(skip_taken_o, skip);
    if (skip) check({rd_en_o, discard_fetch_o}, 2'h0);
    instr_valid_i = 1'b0;
  endtask : run_test
  task automatic test_skips();
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      run_test(btsu_pkg::OPC_SKIP_SET, i[2:0], m, 1'b1);
      run_test(btsu_pkg::OPC_SKIP_SET, i[2:0], ~m, 1'b0);
      run_test(btsu_pkg::OPC_SKIP_CLEAR, i[2:0], ~m, 1'b1);
      run_test(btsu_pkg::OPC_SKIP_CLEAR, i[2:0], m, 1'b0);
    end
  endtask : test_skips
  // Operand address and mode for one access setting
  task automatic addr_case(input logic a, input logic ext, input logic [7:0] f,
                           input logic [11:0] ea, input logic [1:0] em);
    @(negedge mclk_i);
    instr_valid_i = 1'b1;
    instr_i = {btsu_pkg::OPC_SKIP_SET, 3'h0, a, f};
    ext_set_i = ext;
    rd_data_i = 8'h00;
    #1;
    check(rd_addr_o, ea);
    check(addr_mode_o, em);
  endtask : addr_case
  task automatic test_addr();
    addr_case(1'b1, 1'b0, 8'h21, 12'h721, btsu_pkg::BTSU_ADDR_BANKED);
    addr_case(1'b0, 1'b0, 8'h21, 12'h021, btsu_pkg::BTSU_ADDR_ACCESS);
    addr_case(1'b0, 1'b0, 8'h80, 12'hF80, btsu_pkg::BTSU_ADDR_ACCESS);
    addr_case(1'b0, 1'b1, 8'h5F, 12'h3FF, btsu_pkg::BTSU_ADDR_INDEXED);
    addr_case(1'b0, 1'b1, 8'h60, 12'h060, btsu_pkg::BTSU_ADDR_ACCESS);
    addr_case(1'b1, 1'b1, 8'h10, 12'h710, btsu_pkg::BTSU_ADDR_BANKED);
    @(negedge mclk_i);
    instr_i = 16'h8321;
    #1;
    check(is_bit_test_o, 1'b0);
    check(discard_fetch_o, 1'b0);
    instr_valid_i = 1'b0;
  endtask : test_addr
  // Idle word ignored, then reset in a flush cycle
  task automatic test_reset();
    @(negedge mclk_i);
    instr_i = {btsu_pkg::OPC_SKIP_SET, 3'h2, 1'b1, 8'h21};
    rd_data_i = 8'h04;
    #1;
    check({is_bit_test_o, discard_fetch_o}, 2'h0);
    @(negedge mclk_i);
    instr_valid_i = 1'b1;
    #1;
    check(discard_fetch_o, 1'b1);
    @(negedge mclk_i);
    check(no_operation_cycle_o, 1'b1);
    reset_i = 1'b1;
    instr_valid_i = 1'b0;
    @(negedge mclk_i);
    check({no_operation_cycle_o, skip_taken_o}, 2'h0);
    reset_i = 1'b0;
    instr_i = {btsu_pkg::OPC_SKIP_CLEAR, 3'h2, 1'b1, 8'h21};
    rd_data_i = 8'hFB;
    instr_valid_i = 1'b1;
    #1;
    check(discard_fetch_o, 1'b1);
    @(negedge mclk_i);
    check({no_operation_cycle_o, skip_taken_o}, 2'h3);
    instr_valid_i = 1'b0;
  endtask : test_reset
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(negedge mclk_i);
    reset_i = 1'b0;
    test_skips();
    test_addr();
    test_reset();
    tally_and_finish();
  end
endmodule : bit_test_skip_unit_bench
`default_nettype wire

// File: btsu_addr.sv
// Operand address former for the bit-test instructions
`default_nettype none
module btsu_addr (
  input  wire logic                   access_i,
  input  wire logic                   ext_set_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [3:0]             bank_i,
  input  wire logic [11:0]            index_base_i,
  output logic      [11:0]            addr_o,
  output btsu_pkg::btsu_mode_t        mode_o
);
  always_comb begin
    if (!access_i && ext_set_i && reg_addr_i <= btsu_pkg::INDEXED_MAX) begin
      mode_o = btsu_pkg::BTSU_ADDR_INDEXED;
      addr_o = 12'(index_base_i + {4'h0, reg_addr_i});
    end else if (!access_i) begin
      mode_o = btsu_pkg::BTSU_ADDR_ACCESS;
      if (reg_addr_i >= btsu_pkg::ACCESS_SPLIT) begin
        addr_o = {btsu_pkg::ACCESS_HI_BANK, reg_addr_i};
      end else begin
        addr_o = {btsu_pkg::ACCESS_LO_BANK, reg_addr_i};
      end
    end else begin
      mode_o = btsu_pkg::BTSU_ADDR_BANKED;
      addr_o = {bank_i, reg_addr_i};
    end
  end
endmodule : btsu_addr
`default_nettype wire

// File: btsu_core.sv
// Bit-test-and-skip execution unit top
`default_nettype none
module btsu_core (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic                   instr_valid_i,
  input  wire logic [15:0]            instr_i,
  input  wire logic                   ext_set_i,
  input  wire logic [3:0]             bank_select_register_i,
  input  wire logic [11:0]            index_base_i,
  input  wire logic [7:0]             rd_data_i,
  output logic      [11:0]            rd_addr_o,
  output logic                        rd_en_o,
  output logic                        is_bit_test_o,
  output logic                        discard_fetch_o,
  output logic                        no_operation_cycle_o,
  output logic                        skip_taken_o,
  output btsu_pkg::btsu_mode_t        addr_mode_o
);
  btsu_pkg::btsu_state_t state_r;
  btsu_pkg::btsu_state_t state_nxt;
  logic       [3:0]      opc;
  logic       [2:0]      bit_idx;
  logic                  tst_clear;
  logic                  tst_set;
  logic                  bit_val;
  logic                  skip;
  logic                  skip_r;
  logic       [11:0]     addr;
  btsu_pkg::btsu_mode_t  mode;
  logic                  acc_bit;
  logic       [7:0]      f_addr;

  assign opc     = instr_i[btsu_pkg::OPC_MSB:btsu_pkg::OPC_LSB];
  assign bit_idx = instr_i[btsu_pkg::BIT_MSB:btsu_pkg::BIT_LSB];
  assign acc_bit = instr_i[btsu_pkg::ACC_POS];
  assign f_addr  = instr_i[btsu_pkg::REG_MSB:btsu_pkg::REG_LSB];

  assign tst_clear = instr_valid_i && (state_r == btsu_pkg::BTSU_EXEC)
                     && (opc == btsu_pkg::OPC_SKIP_CLEAR);
  assign tst_set   = instr_valid_i && (state_r == btsu_pkg::BTSU_EXEC)
                     && (opc == btsu_pkg::OPC_SKIP_SET);

  btsu_addr u_addr (
    .access_i     (acc_bit),
    .ext_set_i    (ext_set_i),
    .reg_addr_i   (f_addr),
    .bank_i       (bank_select_register_i),
    .index_base_i (index_base_i),
    .addr_o       (addr),
    .mode_o       (mode)
  );

  assign bit_val = rd_data_i[bit_idx];

  assign skip = (tst_set && bit_val) || (tst_clear && !bit_val);

  assign rd_en_o         = tst_clear || tst_set;
  assign rd_addr_o       = addr;
  assign addr_mode_o     = mode;
  assign is_bit_test_o   = tst_clear || tst_set;
  assign discard_fetch_o = skip;
  assign no_operation_cycle_o = (state_r == btsu_pkg::BTSU_FLUSH);
  assign skip_taken_o    = skip_r;

  always_comb begin
    case (state_r)
      btsu_pkg::BTSU_EXEC:  state_nxt = skip ? btsu_pkg::BTSU_FLUSH
                                             : btsu_pkg::BTSU_EXEC;
      btsu_pkg::BTSU_FLUSH: state_nxt = btsu_pkg::BTSU_EXEC;
      default:              state_nxt = btsu_pkg::BTSU_EXEC;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_r <= btsu_pkg::BTSU_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= skip;
    end
  end

  AST_SET_SKIPS: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    tst_set && bit_val |-> discard_fetch_o ##1 no_operation_cycle_o)
    else $error("set test with bit one did not skip");

  AST_SET_HOLDS: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    tst_set && !bit_val |-> !discard_fetch_o ##1 !no_operation_cycle_o)
    else $error("set test with bit zero skipped");

  AST_CLEAR_SKIPS: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    tst_clear && !bit_val |-> discard_fetch_o ##1 no_operation_cycle_o)
    else $error("clear test with bit zero did not skip");

  AST_CLEAR_HOLDS: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    tst_clear && bit_val |-> !discard_fetch_o ##1 !no_operation_cycle_o)
    else $error("clear test with bit one skipped");

  AST_NO_SKIP: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    is_bit_test_o && !discard_fetch_o |=> !no_operation_cycle_o)
    else $error("no-operation cycle without skip");

  AST_ONE_NOP: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    no_operation_cycle_o |=> !no_operation_cycle_o)
    else $error("flush lasted more than one cycle");

  AST_FLUSH_IDLE: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    no_operation_cycle_o |->
      !rd_en_o && !is_bit_test_o && !discard_fetch_o)
    else $error("work done in no-operation cycle");

  AST_SKIP_SOURCE: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    discard_fetch_o |-> is_bit_test_o && rd_en_o)
    else $error("skip without a bit test");

  AST_FLUSH_CAUSE: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    no_operation_cycle_o |-> $past(discard_fetch_o))
    else $error("no-operation cycle without preceding skip");

  AST_SKIP_FLAG: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    discard_fetch_o |=> skip_taken_o)
    else $error("skip flag missing after skip");

  AST_SKIP_FLAG_LOW: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    !discard_fetch_o |=> !skip_taken_o)
    else $error("skip flag without skip");

  AST_RESET_CLEAR: assert property (
    @(posedge mclk_i)
    reset_i |=> !no_operation_cycle_o && !skip_taken_o)
    else $error("flush state survived reset");

  AST_ACCESS: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    rd_en_o && !acc_bit &&
      (!ext_set_i || f_addr > btsu_pkg::INDEXED_MAX) |->
      rd_addr_o[7:0] == f_addr &&
      rd_addr_o[11:8] == (f_addr >= btsu_pkg::ACCESS_SPLIT ?
        btsu_pkg::ACCESS_HI_BANK : btsu_pkg::ACCESS_LO_BANK))
    else $error("access bank address wrong");

  AST_ACCESS_MODE: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    rd_en_o && !acc_bit && !ext_set_i |->
      addr_mode_o == btsu_pkg::BTSU_ADDR_ACCESS)
    else $error("access mode not reported");

  AST_BANKED: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    rd_en_o && acc_bit |->
      rd_addr_o == {bank_select_register_i, f_addr})
    else $error("banked address wrong");

  AST_BANKED_MODE: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    rd_en_o && acc_bit |-> addr_mode_o == btsu_pkg::BTSU_ADDR_BANKED)
    else $error("banked mode not reported");

  AST_INDEXED: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    rd_en_o && !acc_bit && ext_set_i &&
      f_addr <= btsu_pkg::INDEXED_MAX |->
      addr_mode_o == btsu_pkg::BTSU_ADDR_INDEXED)
    else $error("indexed mode not used");

  AST_INDEXED_ADDR: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    rd_en_o && !acc_bit && ext_set_i &&
      f_addr <= btsu_pkg::INDEXED_MAX |->
      rd_addr_o == 12'(index_base_i + {4'h0, f_addr}))
    else $error("indexed address wrong");

  AST_HIGH_DIRECT: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    rd_en_o && !acc_bit && ext_set_i &&
      f_addr > btsu_pkg::INDEXED_MAX |->
      addr_mode_o == btsu_pkg::BTSU_ADDR_ACCESS)
    else $error("high address used indexed mode");

  AST_DECODE: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    is_bit_test_o |-> instr_valid_i && !no_operation_cycle_o &&
      (opc == btsu_pkg::OPC_SKIP_CLEAR || opc == btsu_pkg::OPC_SKIP_SET))
    else $error("non bit-test opcode decoded");

  AST_TAKEN: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    instr_valid_i && !no_operation_cycle_o &&
      (opc == btsu_pkg::OPC_SKIP_CLEAR || opc == btsu_pkg::OPC_SKIP_SET) |->
      is_bit_test_o && rd_en_o)
    else $error("bit test not taken");

  COV_SET_SKIP: cover property (@(posedge mclk_i) tst_set && bit_val);
  COV_CLR_SKIP: cover property (@(posedge mclk_i) tst_clear && !bit_val);
  COV_NO_SKIP: cover property (@(posedge mclk_i)
    is_bit_test_o && !discard_fetch_o);
  COV_INDEXED: cover property (@(posedge mclk_i)
    rd_en_o && addr_mode_o == btsu_pkg::BTSU_ADDR_INDEXED);
  COV_REFUSED: cover property (@(posedge mclk_i)
    no_operation_cycle_o && instr_valid_i);
endmodule : btsu_core
`default_nettype wire

// File: btsu_pkg.sv
// Constants for the bit-test-and-skip execution unit
`default_nettype none
package btsu_pkg;
  localparam int          INSTR_W        = 16;
  localparam int          OPC_MSB        = 15;
  localparam int          OPC_LSB        = 12;
  localparam int          BIT_MSB        = 11;
  localparam int          BIT_LSB        = 9;
  localparam int          ACC_POS        = 8;
  localparam int          REG_MSB        = 7;
  localparam int          REG_LSB        = 0;
  localparam logic [3:0]  OPC_SKIP_CLEAR = 4'hB;
  localparam logic [3:0]  OPC_SKIP_SET   = 4'hA;
  localparam logic [7:0]  INDEXED_MAX    = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [11:0] ADDR_RESET     = 12'h000;
  typedef enum logic [1:0] {
    BTSU_ADDR_ACCESS  = 2'h0,
    BTSU_ADDR_BANKED  = 2'h1,
    BTSU_ADDR_INDEXED = 2'h2
  } btsu_mode_t;
  typedef enum logic [0:0] {
    BTSU_EXEC = 1'h0,
    BTSU_FLUSH = 1'h1
  } btsu_state_t;
endpackage : btsu_pkg
`default_nettype wire
